// ==== common/cmd_decoder_pkg.sv ====
// constants, symbol codes and types of the serial command decoder
package cmd_decoder_pkg;

  // clock and timing
  localparam int CLK_MHZ         = 200;
  localparam int IDLE_TIME_NS    = 10000;
  localparam int IDLE_CYCLES_INT = IDLE_TIME_NS * CLK_MHZ / 1000;
  localparam logic [11:0] IDLE_CYCLES = IDLE_CYCLES_INT[11:0];

  // frame layout
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] LAST_BIT = 4'hf;

  // special symbols and frames
  localparam logic [7:0]  SYM_SYNC_A  = 8'h81;
  localparam logic [7:0]  SYM_SYNC_B  = 8'h7e;
  localparam logic [15:0] SYNC_FRAME  = {SYM_SYNC_A, SYM_SYNC_B};
  localparam logic [7:0]  SYM_CLOCK   = 8'haa;

  // command symbols
  localparam logic [7:0] CMD_CLEAR  = 8'h5a;
  localparam logic [7:0] CMD_PULSE  = 8'h5c;
  localparam logic [7:0] CMD_CAL    = 8'h63;
  localparam logic [7:0] CMD_WRREG  = 8'h66;
  localparam logic [7:0] CMD_REGISTER_READ_CMD  = 8'h65;
  localparam logic [7:0] CMD_RDTAG  = 8'h69;

  // trigger symbols, index equals the four-crossing pattern
  localparam logic [7:0] TRIG_SYM [1:15] = '{
    8'h2b, 8'h2d, 8'h2e, 8'h33, 8'h35, 8'h36, 8'h39, 8'h3a,
    8'h3c, 8'h4b, 8'h4d, 8'h4e, 8'h53, 8'h55, 8'h56};

  // code sizes
  localparam int DATA_SYMBOLS = 32;
  localparam int TAG_COUNT    = 54;
  localparam logic [8:0] REG_COUNT = 9'h08a;

  // data frames that follow the command frame of each long command
  localparam logic [1:0] CAL_FRAMES   = 2'h2;
  localparam logic [1:0] WRITE_FRAMES = 2'h3;
  localparam logic [1:0] READ_FRAMES  = 2'h1;
  localparam logic [1:0] TAG_FRAMES   = 2'h1;

  // request queue
  localparam int REQ_W      = 27;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {REQ_WRITE, REQ_READ, REQ_READ_NULL, REQ_PORTAL} req_kind_t;
  typedef enum logic [2:0] {LC_NONE, LC_CAL, LC_WRITE, LC_READ, LC_TAGREAD} long_cmd_t;

endpackage : cmd_decoder_pkg

// ==== src/cmd_decoder.sv ====
// serial command stream decoder: framing, symbol check, addressing, execution
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - stream is back-to-back 16-bit frames of two 8-bit symbols
// - frames decoded singly; short commands act now, long after last frame
// - short commands between long-command frames run; long command resumes
// - chip identity taken from four strap inputs, pulled high by default
// - first frame holds command and identity; identity above 15 is broadcast
// - commands for other chips are tracked frame by frame, never executed
// - clock pattern, alignment and trigger frames are always broadcast
// - invalid symbols are recognised; single bit errors always detected
// - 32 data symbols carry 5 bits; data frame carries 10 bits
// - any valid second trigger symbol maps to one of 54 tags
// - trigger first symbol is one of 15, giving the crossing pattern
// - alignment frame is 1000_0001 then 0111_1110
// - clock pattern frame does nothing; usable as idle filler
// - addressed commands identified by their first symbol codes
// - register write payload: mode and address, then data, padded last
// - register read carries address; injection carries 20 data bits
// - clear command erases whole data path
// - raw command stream optionally copied to general output
// - low transition rate on command input produces chip reset
// - write mode bit selects repeated portal writes until next long command
// - unused address write ignored; unused read returns zero with address
// - frame decode held idle until clock stable; decode only under frame lock
// - all-zero trigger pattern never encoded
module cmd_decoder
  import cmd_decoder_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // recovered line
  input  wire logic             line_bit,
  input  wire logic             line_bit_en,
  input  wire logic             clk_stable,
  input  wire logic             frame_lock,
  // straps and configuration
  input  wire logic [3:0]       chip_id_strap,
  input  wire logic             raw_copy_en,
  // general purpose output and chip reset
  output logic                  raw_copy_out,
  output logic                  chip_reset_out,
  // short command and injection outputs
  output logic                  clear_pulse,
  output logic                  global_pulse,
  output logic                  trig_pulse,
  output logic [3:0]            trig_pattern,
  output logic [5:0]            trig_tag,
  output logic                  cal_pulse,
  output logic [19:0]           cal_data,
  // register requests
  output logic                  req_valid,
  input  wire logic             req_ready,
  output logic [1:0]            req_kind,
  output logic [8:0]            req_addr,
  output logic [15:0]           req_data,
  // error events
  output logic                  err_symbol,
  output logic                  err_unexpected,
  output logic                  err_overrun
);

  ////////////////////////////////////////////////////////////////////////////
  // symbol functions

  function automatic logic sym_shape(input logic [7:0] s);
    return ($countones(s) == 4) && (s[7:5] != 3'h0) && (s[7:5] != 3'h7)
           && (s[2:0] != 3'h0) && (s[2:0] != 3'h7);
  endfunction : sym_shape

  function automatic logic [3:0] trig_pat(input logic [7:0] s);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 1; i <= 15; i++) begin
      if (s == TRIG_SYM[i]) p = 4'(i);
    end
    return p;
  endfunction : trig_pat

  function automatic logic is_cmd(input logic [7:0] s);
    return (s == CMD_CLEAR) || (s == CMD_PULSE) || (s == CMD_CAL)
           || (s == CMD_WRREG) || (s == CMD_REGISTER_READ_CMD) || (s == CMD_RDTAG);
  endfunction : is_cmd

  function automatic logic is_special(input logic [7:0] s);
    return (s == SYM_CLOCK) || is_cmd(s) || (trig_pat(s) != 4'h0);
  endfunction : is_special

  // data values and tags are ranks of the symbol among its class
  function automatic logic [7:0] rank_below(input logic [7:0] s, input logic data_only);
    logic [7:0] n;
    logic [7:0] v;
    n = 8'h0;
    for (int i = 0; i < 256; i++) begin
      v = 8'(i);
      if (v < s && sym_shape(v) && (!data_only || !is_special(v)))
        n = n + 8'h1;
    end
    return n;
  endfunction : rank_below

  function automatic logic is_data(input logic [7:0] s);
    return sym_shape(s) && !is_special(s) && (rank_below(s, 1'b1) < 8'(DATA_SYMBOLS));
  endfunction : is_data

  function automatic logic [4:0] data_val(input logic [7:0] s);
    logic [7:0] r;
    r = rank_below(s, 1'b1);
    return r[4:0];
  endfunction : data_val

  function automatic logic tag_ok(input logic [7:0] s);
    return sym_shape(s) && (rank_below(s, 1'b0) < 8'(TAG_COUNT));
  endfunction : tag_ok

  ////////////////////////////////////////////////////////////////////////////
  // framing, raw copy, activity watch, strap capture

  logic [15:0] shift_r, shift_nxt, frm_r, frm_nxt;
  logic [3:0]  bit_cnt_r, bit_cnt_nxt;
  logic        frm_pend_r, frm_pend_nxt, overrun_nxt, frm_take;
  logic        last_bit_r, raw_nxt, idle_rst_nxt;
  logic [11:0] idle_cnt_r, idle_cnt_nxt;
  logic [3:0]  id_r, id_nxt;
  logic        id_cap_r;
  logic [15:0] shifted;
  logic        frm_done;

  always_comb begin
    shifted      = {shift_r[14:0], line_bit};
    shift_nxt    = shift_r;
    bit_cnt_nxt  = bit_cnt_r;
    frm_done     = 1'b0;
    if (line_bit_en) begin
      shift_nxt = shifted;
      // alignment frame pins the boundary
      if (shifted == SYNC_FRAME || bit_cnt_r == LAST_BIT) begin
        bit_cnt_nxt = 4'h0;
        frm_done    = frame_lock;
      end else begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
    end
    frm_nxt      = frm_done ? shifted : frm_r;
    frm_pend_nxt = frm_done || (frm_pend_r && !frm_take);
    // decode lags a full frame behind only while the queue is full
    overrun_nxt  = frm_done && frm_pend_r && !frm_take;
    raw_nxt      = raw_copy_en && line_bit;
    idle_cnt_nxt = (line_bit != last_bit_r) ? 12'h0
                 : (idle_cnt_r == IDLE_CYCLES) ? idle_cnt_r : idle_cnt_r + 12'h1;
    idle_rst_nxt = idle_cnt_r == IDLE_CYCLES;
    id_nxt       = id_cap_r ? id_r : chip_id_strap;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r        <= '0;
      bit_cnt_r      <= '0;
      frm_r          <= '0;
      frm_pend_r     <= 1'b0;
      err_overrun    <= 1'b0;
      last_bit_r     <= 1'b0;
      raw_copy_out   <= 1'b0;
      idle_cnt_r     <= '0;
      chip_reset_out <= 1'b0;
      id_r           <= 4'hf;
      id_cap_r       <= 1'b0;
    end else begin
      shift_r        <= shift_nxt;
      bit_cnt_r      <= bit_cnt_nxt;
      frm_r          <= frm_nxt;
      frm_pend_r     <= clk_stable && frm_pend_nxt;
      err_overrun    <= clk_stable && overrun_nxt;
      last_bit_r     <= line_bit;
      raw_copy_out   <= raw_nxt;
      idle_cnt_r     <= idle_cnt_nxt;
      chip_reset_out <= idle_rst_nxt;
      id_r           <= id_nxt;
      id_cap_r       <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decode and command execution

  long_cmd_t   long_r, long_nxt;
  logic [1:0]  left_r, left_nxt;
  logic        mine_r, mine_nxt, rep_r, rep_nxt, rep_mine_r, rep_mine_nxt;
  logic [29:0] coll_r, coll_nxt;
  logic        clr_nxt, gp_nxt, tp_nxt, cp_nxt, es_nxt, eu_nxt;
  logic [3:0]  tpat_nxt;
  logic [5:0]  ttag_nxt;
  logic [19:0] cdat_nxt;
  logic        push;
  logic [REQ_W-1:0] push_word;
  logic        fifo_in_ready;
  logic [REQ_W-1:0] pop_word;
  logic [7:0]  s0, s1;
  logic [4:0]  s0_val, s1_val;
  logic        for_me;
  logic [7:0]  tag_rank;

  always_comb begin
    s0       = frm_r[15:8];
    s1       = frm_r[7:0];
    s0_val   = data_val(s0);
    s1_val   = data_val(s1);
    frm_take = frm_pend_r && fifo_in_ready;
    for_me   = s1_val > 5'h0f || s1_val[3:0] == id_r;
    tag_rank = rank_below(s1, 1'b0);
    long_nxt = long_r;
    left_nxt = left_r;
    mine_nxt = mine_r;
    rep_nxt  = rep_r;
    rep_mine_nxt = rep_mine_r;
    coll_nxt = coll_r;
    clr_nxt  = 1'b0;
    gp_nxt   = 1'b0;
    tp_nxt   = 1'b0;
    cp_nxt   = 1'b0;
    es_nxt   = 1'b0;
    eu_nxt   = 1'b0;
    tpat_nxt = trig_pattern;
    ttag_nxt = trig_tag;
    cdat_nxt = cal_data;
    push     = 1'b0;
    push_word = '0;
    if (frm_take) begin
      if (frm_r == SYNC_FRAME || (s0 == SYM_CLOCK && s1 == SYM_CLOCK)) begin
        // alignment and filler frames carry no action
      end else if (trig_pat(s0) != 4'h0 && tag_ok(s1)) begin
        tp_nxt   = 1'b1;
        tpat_nxt = trig_pat(s0);
        ttag_nxt = tag_rank[5:0];
      end else if (is_cmd(s0) && is_data(s1)) begin
        if (s0 == CMD_CLEAR) begin
          clr_nxt = for_me;
        end else if (s0 == CMD_PULSE) begin
          gp_nxt = for_me;
        end else begin
          // a new long command replaces any pending one and ends repeat mode
          mine_nxt = for_me;
          coll_nxt = '0;
          rep_nxt  = 1'b0;
          case (s0)
            CMD_CAL: begin
              long_nxt = LC_CAL;
              left_nxt = CAL_FRAMES;
            end
            CMD_WRREG: begin
              long_nxt = LC_WRITE;
              left_nxt = WRITE_FRAMES;
            end
            CMD_REGISTER_READ_CMD: begin
              long_nxt = LC_READ;
              left_nxt = READ_FRAMES;
            end
            default: begin
              long_nxt = LC_TAGREAD;
              left_nxt = TAG_FRAMES;
            end
          endcase
        end
      end else if (is_data(s0) && is_data(s1)) begin
        if (long_r != LC_NONE) begin
          coll_nxt = {coll_r[19:0], s0_val, s1_val};
          left_nxt = left_r - 2'h1;
          if (long_r == LC_WRITE && left_r == WRITE_FRAMES && s0_val[4]) begin
            long_nxt     = LC_NONE;
            rep_nxt      = 1'b1;
            rep_mine_nxt = mine_r;
          end else if (left_r == 2'h1) begin
            long_nxt = LC_NONE;
            case (long_r)
              LC_CAL: begin
                cp_nxt   = mine_r;
                cdat_nxt = coll_nxt[19:0];
              end
              LC_WRITE: begin
                // unused addresses are dropped silently
                push = mine_r && {coll_nxt[28:25], coll_nxt[24:20]} < REG_COUNT;
                push_word = {REQ_WRITE, coll_nxt[28:25], coll_nxt[24:20],
                             coll_nxt[19:5], coll_nxt[4]};
              end
              LC_READ: begin
                push = mine_r;
                push_word = {({coll_nxt[8:5], coll_nxt[4:0]} < REG_COUNT) ? REQ_READ
                             : REQ_READ_NULL, coll_nxt[8:5], coll_nxt[4:0], 16'h0};
              end
              default: begin
              end
            endcase
          end
        end else if (rep_r) begin
          push = rep_mine_r;
          push_word = {REQ_PORTAL, 9'h000, 6'h00, s0_val, s1_val};
        end else begin
          eu_nxt = 1'b1;
        end
      end else begin
        es_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      long_r       <= LC_NONE;
      left_r       <= '0;
      mine_r       <= 1'b0;
      rep_r        <= 1'b0;
      rep_mine_r   <= 1'b0;
      coll_r       <= '0;
      clear_pulse  <= 1'b0;
      global_pulse <= 1'b0;
      trig_pulse   <= 1'b0;
      trig_pattern <= '0;
      trig_tag     <= '0;
      cal_pulse    <= 1'b0;
      cal_data     <= '0;
      err_symbol   <= 1'b0;
      err_unexpected <= 1'b0;
    end else if (!clk_stable) begin
      long_r       <= LC_NONE;
      rep_r        <= 1'b0;
      clear_pulse  <= 1'b0;
      global_pulse <= 1'b0;
      trig_pulse   <= 1'b0;
      cal_pulse    <= 1'b0;
      err_symbol   <= 1'b0;
      err_unexpected <= 1'b0;
    end else begin
      long_r       <= long_nxt;
      left_r       <= left_nxt;
      mine_r       <= mine_nxt;
      rep_r        <= rep_nxt;
      rep_mine_r   <= rep_mine_nxt;
      coll_r       <= coll_nxt;
      clear_pulse  <= clr_nxt;
      global_pulse <= gp_nxt;
      trig_pulse   <= tp_nxt;
      trig_pattern <= tpat_nxt;
      trig_tag     <= ttag_nxt;
      cal_pulse    <= cp_nxt;
      cal_data     <= cdat_nxt;
      err_symbol   <= es_nxt;
      err_unexpected <= eu_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register request queue

  req_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_req_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (pop_word)
  );

  assign req_kind = pop_word[26:25];
  assign req_addr = pop_word[24:16];
  assign req_data = pop_word[15:0];

endmodule : cmd_decoder

// ==== src/req_fifo.sv ====
// small synchronous fifo for decoded register requests
`timescale 1ns/100ps
module req_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r, wr_nxt;
  logic [AW:0]      rd_r, rd_nxt;
  logic             push, pop;

  always_comb begin
    in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
    out_valid = wr_r != rd_r;
    out_data  = mem_r[rd_r[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_nxt    = push ? wr_r + 1'b1 : wr_r;
    rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // storage carries no reset, only the pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

endmodule : req_fifo

// ==== tb/cmd_decoder_properties.sv ====
// concurrent checks on the command decoder ports
`timescale 1ns/100ps
module cmd_decoder_props
  import cmd_decoder_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // line and controls
  input wire logic        line_bit,
  input wire logic        clk_stable,
  input wire logic        frame_lock,
  input wire logic        raw_copy_en,
  // event outputs
  input wire logic        raw_copy_out,
  input wire logic        chip_reset_out,
  input wire logic        clear_pulse,
  input wire logic        global_pulse,
  input wire logic        trig_pulse,
  input wire logic [3:0]  trig_pattern,
  input wire logic [5:0]  trig_tag,
  input wire logic        cal_pulse,
  input wire logic        err_symbol,
  // request queue
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [1:0]  req_kind,
  input wire logic [8:0]  req_addr,
  input wire logic [15:0] req_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [11:0] idle_r;
  logic [11:0] idle_nxt;
  logic        last_r;
  logic        act;

  // cycles since the line last changed, saturating
  always_comb begin
    idle_nxt = idle_r;
    if (line_bit != last_r) idle_nxt = 12'h000;
    else if (idle_r != 12'hfff) idle_nxt = idle_r + 12'h001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 12'h000;
      last_r <= 1'b0;
    end else begin
      idle_r <= idle_nxt;
      last_r <= line_bit;
    end
  end
  assign act = clear_pulse | global_pulse | trig_pulse | cal_pulse;

  //////////////////////////////////////////////////////////////////////
  property p_raw_copy;
    $past(rst_n) |-> raw_copy_out == ($past(raw_copy_en) & $past(line_bit));
  endproperty
  a_raw_copy: assert property (p_raw_copy) else $error("raw copy wrong");
  property p_unstable;
    !clk_stable |=> !act && !err_symbol;
  endproperty
  a_unstable: assert property (p_unstable) else $error("action while clock unstable");
  property p_unlocked;
    !frame_lock [*3] |-> !act;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("action without lock");
  property p_trig_pat;
    trig_pulse |-> trig_pattern != 4'h0;
  endproperty
  a_trig_pat: assert property (p_trig_pat) else $error("empty trigger pattern");
  property p_trig_tag;
    trig_pulse |-> int'(trig_tag) < TAG_COUNT;
  endproperty
  a_trig_tag: assert property (p_trig_tag) else $error("tag out of range");
  property p_err_quiet;
    err_symbol |-> !act;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("bad frame executed");
  property p_hold;
    req_valid && !req_ready |=> req_valid && $stable(req_kind) && $stable(req_addr)
      && $stable(req_data);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped while stalled");
  property p_portal;
    req_valid && req_kind == REQ_PORTAL |-> req_addr == 9'h000 && req_data[15:10] == 6'h00;
  endproperty
  a_portal: assert property (p_portal) else $error("portal word malformed");
  property p_read_kind;
    req_valid && req_kind inside {REQ_READ, REQ_READ_NULL}
      |-> (req_kind == REQ_READ_NULL) == (req_addr >= REG_COUNT);
  endproperty
  a_read_kind: assert property (p_read_kind) else $error("read kind wrong");
  property p_idle_hi;
    idle_r > IDLE_CYCLES + 12'h004 |-> chip_reset_out;
  endproperty
  a_idle_hi: assert property (p_idle_hi) else $error("no reset on quiet line");
  property p_idle_lo;
    idle_r > 12'h004 && idle_r < IDLE_CYCLES - 12'h004 |-> !chip_reset_out;
  endproperty
  a_idle_lo: assert property (p_idle_lo) else $error("early reset");
endmodule : cmd_decoder_props

bind cmd_decoder cmd_decoder_props u_props (.*);

// ==== tb/line_sender.sv ====
// back-end controller model streaming frames onto the command line
`timescale 1ns/100ps
module line_sender
  import cmd_decoder_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // stop all line activity
  input  wire logic mute,
  // serial line
  output logic      line_bit = 1'b0,
  output logic      line_bit_en = 1'b0
);
  logic [15:0] q[$];
  logic [15:0] sh_r;
  logic [15:0] fr;
  int          ph_r;
  int          nb_r;
  int          nfr_r;
  int          syncs_r;

  // four bits in every five clocks gives the 160 of 200 rate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 0;
      nb_r <= 0;
      nfr_r <= 0;
      syncs_r <= 0;
      line_bit <= 1'b0;
      line_bit_en <= 1'b0;
    end else if (mute) begin
      line_bit_en <= 1'b0;
    end else begin
      ph_r <= (ph_r == 4) ? 0 : ph_r + 1;
      line_bit_en <= ph_r != 4;
      if (ph_r == 4) begin
        // no bit owed here, so never show the old one
        line_bit <= ~line_bit;
      end else begin
        fr = sh_r;
        if (nb_r == 0) begin
          if (nfr_r % 32 == 0) begin
            fr = SYNC_FRAME;
            syncs_r <= syncs_r + 1;
          end else if (q.size() != 0) begin
            fr = q.pop_front();
          end else begin
            fr = {SYM_CLOCK, SYM_CLOCK};
          end
          nfr_r <= nfr_r + 1;
        end
        line_bit <= fr[15];
        sh_r <= {fr[14:0], 1'b0};
        nb_r <= (nb_r == 15) ? 0 : nb_r + 1;
      end
    end
  end
endmodule : line_sender

// ==== tb/tb_top.sv ====
// self-checking bench for the serial command decoder
`timescale 1ns/100ps
module tb_top;
  import cmd_decoder_pkg::*;
  localparam logic [3:0] K_TRIG = 4'h1, K_CLR = 4'h2, K_GP = 4'h3, K_CAL = 4'h4;
  localparam logic [3:0] K_ERS = 4'h5, K_ERU = 4'h6, K_ERO = 4'h7, K_RST = 4'h8;
  logic        clk = 1'b0, rst_n = 1'b0, clk_stable = 1'b0, frame_lock = 1'b0;
  logic        raw_copy_en = 1'b0, req_ready = 1'b0, mute = 1'b0, hold = 1'b0;
  logic [3:0]  chip_id_strap = 4'h0;
  logic        line_bit, line_bit_en, raw_copy_out, chip_reset_out, clear_pulse;
  logic        global_pulse, trig_pulse, cal_pulse, req_valid, err_symbol;
  logic        err_unexpected, err_overrun, prev_rst = 1'b0;
  logic [3:0]  trig_pattern;
  logic [5:0]  trig_tag;
  logic [19:0] cal_data, d;
  logic [1:0]  req_kind;
  logic [8:0]  req_addr;
  logic [15:0] req_data;
  logic [9:0]  v;
  logic [4:0]  me;
  logic [31:0] evq[$];
  logic [26:0] rqq[$];
  int          fails = 0, check_count = 0, cycles = 0;

  always #2.5 clk = ~clk;
  cmd_decoder u_dut (.*);
  line_sender u_send (.*);

  //////////////////////////////////////////////////////////////////////
  // symbol of rank v among the shaped symbols; tags also rank the special ones
  function automatic logic [7:0] sym(input logic [5:0] v, input bit tag);
    logic [7:0] s;
    bit         ex;
    int         r;
    r = 0;
    for (int i = 0; i < 256; i++) begin
      s = i[7:0];
      ex = $countones(s) != 4 || s[7:5] inside {3'h0, 3'h7} || s[2:0] inside {3'h0, 3'h7};
      if (!tag) begin
        ex = ex || s inside {SYM_CLOCK, CMD_CLEAR, CMD_PULSE, CMD_CAL, CMD_WRREG, CMD_REGISTER_READ_CMD,
                             CMD_RDTAG};
        for (int k = 1; k < 16; k++) ex = ex || s == TRIG_SYM[k];
      end
      if (!ex && r == int'(v)) return s;
      if (!ex) r++;
    end
    return 8'h00;
  endfunction : sym
  function automatic logic [15:0] df(input logic [9:0] x);
    return {sym({1'b0, x[9:5]}, 1'b0), sym({1'b0, x[4:0]}, 1'b0)};
  endfunction : df
  task automatic send(input logic [15:0] f);
    u_send.q.push_back(f);
  endtask : send
  task automatic cmd(input logic [7:0] c, input logic [4:0] id);
    send({c, sym({1'b0, id}, 1'b0)});
  endtask : cmd
  task automatic trig(input int p, input bit bad);
    logic [5:0] t;
    t = 6'($urandom % 54);
    send({TRIG_SYM[p] ^ {7'h0, bad}, sym(t, 1'b1)});
    evq.push_back(bad ? {K_ERS, 28'h0} : {K_TRIG, 18'h0, p[3:0], t});
  endtask : trig
  task automatic wr(input logic [4:0] id, input bit mine, input logic [8:0] a,
                    input logic [15:0] x, input int mid);
    cmd(CMD_WRREG, id);
    send(df({1'b0, a}));
    if (mid != 0) trig(3, mid == 2);
    send(df(x[15:6]));
    send(df({x[5:0], 4'h0}));
    if (mine && a < REG_COUNT) rqq.push_back({REQ_WRITE, a, x});
  endtask : wr
  task automatic rd(input logic [4:0] id, input logic [8:0] a);
    cmd(CMD_REGISTER_READ_CMD, id);
    send(df({1'b0, a}));
    rqq.push_back({(a < REG_COUNT) ? REQ_READ : REQ_READ_NULL, a, 16'h0});
  endtask : rd
  task automatic idle();
    while (u_send.q.size() != 0) @(negedge clk);
    repeat (50) @(negedge clk);
  endtask : idle
  task automatic check_ev(input logic [31:0] got);
    logic [31:0] e;
    e = (evq.size() != 0) ? evq.pop_front() : 32'hffffffff;
    check_count++;
    if (got !== e) begin
      fails++;
      $display("ERROR at %0t: event %h expected %h", $time, got, e);
    end
  endtask : check_ev
  task automatic check_rq(input logic [26:0] got);
    logic [26:0] e;
    e = (rqq.size() != 0) ? rqq.pop_front() : 27'h7ffffff;
    check_count++;
    if (got !== e) begin
      fails++;
      $display("ERROR at %0t: request %h expected %h", $time, got, e);
    end
  endtask : check_rq
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  //////////////////////////////////////////////////////////////////////
  // monitor; also drives the request stall so both see the same edge
  always @(negedge clk) begin
    req_ready = !hold && ($urandom % 3 != 0);
    if (rst_n) begin
      if (trig_pulse) check_ev({K_TRIG, 18'h0, trig_pattern, trig_tag});
      if (clear_pulse) check_ev({K_CLR, 28'h0});
      if (global_pulse) check_ev({K_GP, 28'h0});
      if (cal_pulse) check_ev({K_CAL, 8'h0, cal_data});
      if (err_symbol) check_ev({K_ERS, 28'h0});
      if (err_unexpected) check_ev({K_ERU, 28'h0});
      if (err_overrun) check_ev({K_ERO, 28'h0});
      if (chip_reset_out && !prev_rst) check_ev({K_RST, 28'h0});
      if (req_valid && req_ready)
        check_rq({req_kind, req_addr, req_data});
    end
    prev_rst = chip_reset_out;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(87));
    chip_id_strap = 4'($urandom);
    me = {1'b0, chip_id_strap};
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (30) @(negedge clk);
    clk_stable = 1'b1;
    // lock only once a sync frame has fixed the boundary
    while (u_send.syncs_r < 2) @(negedge clk);
    repeat (24) @(negedge clk);
    frame_lock = 1'b1;
    raw_copy_en = 1'b1;
    for (int p = 1; p < 16; p++) trig(p, 1'b0);
    // own link per chip, so clear is allowed; tag readback is never sent
    for (int i = 0; i < 6; i++) begin
      cmd(i < 3 ? CMD_CLEAR : CMD_PULSE, i % 3 == 0 ? me : i % 3 == 1 ?
          5'(16 + $urandom % 16) : me ^ 5'h01);
      if (i % 3 != 2) evq.push_back({i < 3 ? K_CLR : K_GP, 28'h0});
    end
    wr(me, 1'b1, 9'($urandom % int'(REG_COUNT)), 16'($urandom), 1);
    wr(me ^ 5'h01, 1'b0, 9'h005, 16'($urandom), 0);
    wr(5'h1f, 1'b1, REG_COUNT + 9'($urandom % 300), 16'($urandom), 2);
    rd(me, 9'($urandom % int'(REG_COUNT)));
    rd(5'h10, 9'h1ff);
    d = 20'($urandom);
    cmd(CMD_CAL, me);
    send(df(d[19:10]));
    send(df(d[9:0]));
    evq.push_back({K_CAL, 8'h0, d});
    cmd(CMD_WRREG, me);
    send(df(10'h200));
    for (int i = 0; i < 3; i++) begin
      v = 10'($urandom);
      send(df(v));
      rqq.push_back({REQ_PORTAL, 9'h000, 6'h00, v});
      if (i == 1) trig(7, 1'b0);
    end
    rd(me, 9'h001);
    send(df(10'h0aa));
    evq.push_back({K_ERU, 28'h0});
    idle();
    raw_copy_en = 1'b0;
    frame_lock = 1'b0;
    send({TRIG_SYM[5], sym(6'h00, 1'b1)});
    idle();
    frame_lock = 1'b1;
    @(posedge clk) hold = 1'b1;
    for (int i = 0; i < 8; i++) rd(me, 9'(i));
    while (u_send.q.size() != 0) @(negedge clk);
    // release before a second frame can pile up behind the full queue
    repeat (24) @(negedge clk);
    @(posedge clk) hold = 1'b0;
    idle();
    evq.push_back({K_RST, 28'h0});
    mute = 1'b1;
    repeat (2100) @(negedge clk);
    check_ev(32'hffffffff);
    check_rq(27'h7ffffff);
    tally_and_finish();
  end
endmodule : tb_top
